// ### rtl/ppc_port.sv
// Port pin control: per-pin control registers, global writes, pin event flags, APB slave
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "ppc_map.svh"

module ppc_port
   import ppc_pkg::*;
#(
   parameter int          NUM_PINS     = 32,
   parameter logic [31:0] SLEW_CAP     = 32'hFFFFFFFF,
   parameter logic [31:0] PULL_CAP     = 32'hFFFFFFFF,
   parameter logic [31:0] PULL_DIR_CAP = 32'hFFFFFFFF,
   parameter logic [31:0] IRQ_CAP      = 32'hFFFFFFFF,
   parameter logic [31:0] SPECIAL_PINS = 32'h00000000
) (
   // Clock and reset
   input  wire logic                           sys_clk,
   input  wire logic                           arst_n,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [`PPC_ADDR_W-1:0]         paddr,
   input  wire logic [31:0]                    pwdata,
   output logic [31:0]                         prdata,
   output logic                                pready,
   output logic                                pslverr,
   // Port state
   input  wire logic                           port_enable,
   // Peripheral side of each pin
   input  wire logic [NUM_PINS-1:0]            periph_out,
   input  wire logic [NUM_PINS-1:0]            periph_drive,
   input  wire logic [NUM_PINS-1:0]            periph_pull_off,
   // Pads
   input  wire logic [NUM_PINS-1:0]            pad_in,
   output logic [NUM_PINS-1:0]                 pad_out,
   output ppc_pad_ctl_t [NUM_PINS-1:0]         pad_ctl,
   // Towards the data input register and the interrupt controller
   output logic [NUM_PINS-1:0]                 pin_input_level,
   output logic                                port_irq
);


   // Register map, byte addresses on the peripheral bus:
   //   0x00 + 4*n   control register of pin n, for n below NUM_PINS
   //   0x80         global write, low group of pins
   //   0x84         global write, high group of pins
   //   0xA0         pin event flags, write one to clear
   // Every other address answers with pslverr, reads zero and ignores writes.
   // Misaligned addresses are refused the same way, so a byte or half-word
   // store that the bus turns into an odd address never lands half-done.

   // Control register layout:
   //   [0]      pull direction, 1 selects pull-up
   //   [1]      pull resistor on
   //   [2]      slow slew
   //   [4]      passive filter
   //   [6]      high drive
   //   [10:8]   mux field, 0 parks the pin with every digital path off
   //   [19:16]  event configuration
   //   [24]     event flag, write one to clear
   // Bits not listed read zero and ignore writes.

   // Event configuration codes:
   //   0 off, 1 rising, 2 falling, 3 both edges, 4 low level, 5 high level
   // Unused codes never set the flag, so a stray value can raise the interrupt only through a flag that was already set.

   // Bus timing:
   //   The address is decoded in the setup cycle and pready rises in the
   //   first access cycle, so every transfer completes with no wait state.
   //   Writes take effect on the edge that closes the access phase.
   //   Read data is captured in the setup cycle and held until the next
   //   read setup, which keeps prdata quiet between transfers.

   // Capability masks:
   //   A clear bit in SLEW_CAP, PULL_CAP or PULL_DIR_CAP makes the matching
   //   control bit of that pin read zero and ignore writes.
   //   A clear bit in IRQ_CAP keeps the event configuration at off and the
   //   flag at zero for that pin.
   //   A set bit in SPECIAL_PINS lets the routed peripheral take the pull
   //   away, as debug, reset and one-way peripheral pins need.

   // Register kind for an address; read and write share it
   function automatic ppc_reg_kind_t reg_kind(input logic [`PPC_ADDR_W-1:0] a);
      if (a[1:0] != 2'h0)
         reg_kind = PPC_REG_NONE;
      else if (a <= `PPC_PCR_LAST && a[`PPC_ADDR_W-1:2] < NUM_PINS)
         reg_kind = PPC_REG_PCR;
      else if (a == `PPC_GPW_LOW)
         reg_kind = PPC_REG_GPW_LOW;
      else if (a == `PPC_GPW_HIGH)
         reg_kind = PPC_REG_GPW_HIGH;
      else if (a == `PPC_FLAGS)
         reg_kind = PPC_REG_FLAGS;
      else
         reg_kind = PPC_REG_NONE;
   endfunction : reg_kind

   // Writable low-half bits of one pin
   function automatic logic [15:0] low_mask(input int pin);
      logic [15:0] m;
      m = `PPC_LOW_FIXED_MASK;
      m[`PPC_SLEW_BIT]     = SLEW_CAP[pin];
      m[`PPC_PULL_ON_BIT]  = PULL_CAP[pin];
      m[`PPC_PULL_DIR_BIT] = PULL_DIR_CAP[pin];
      low_mask = m;
   endfunction : low_mask

   logic [15:0]         pcr_low   [NUM_PINS];
   logic [3:0]          irq_cfg   [NUM_PINS];
   logic [NUM_PINS-1:0] pin_event_flag;
   logic [NUM_PINS-1:0] level_q;
   logic [NUM_PINS-1:0] event_hit;
   logic [NUM_PINS-1:0] flag_clear;
   logic [NUM_PINS-1:0] gpw_select;
   logic [NUM_PINS-1:0] irq_enabled;

   ppc_reg_kind_t       kind;
   logic                wr_done;
   logic [4:0]          pcr_index;
   logic [15:0]         global_write_value;
   logic [15:0]         global_write_pin_select;

   assign kind                    = reg_kind(paddr);
   // Write lands on the completing edge of the access phase
   assign wr_done                 = psel & penable & pready & pwrite;
   assign pcr_index               = paddr[6:2];
   assign global_write_value      = pwdata[15:0];
   assign global_write_pin_select = pwdata[31:`PPC_GPW_SEL_LSB];


   // Global writes only reach the lower half of the selected registers.
   // Pins at or above NUM_PINS simply find nothing to select, so a narrow
   // port needs no special case here.

   // Pin selection for a global write, low register for pins 15..0, high for 31..16
   always_comb begin
      gpw_select = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         if (wr_done && kind == PPC_REG_GPW_LOW && i < 16)
            gpw_select[i] = global_write_pin_select[i];
         else if (wr_done && kind == PPC_REG_GPW_HIGH && i >= 16)
            gpw_select[i] = global_write_pin_select[i - 16];
      end
   end


   // The flag has one home; both addresses clear the same bit.
   // A zero written anywhere leaves the flag as it is.

   // Write-one-to-clear from either the status register or the pin's own register
   always_comb begin
      flag_clear = '0;
      if (wr_done && kind == PPC_REG_FLAGS)
         flag_clear = pwdata[NUM_PINS-1:0];
      else if (wr_done && kind == PPC_REG_PCR && pwdata[`PPC_FLAG_BIT])
         flag_clear[pcr_index] = 1'b1;
   end


   // A registered answer costs no wait state here, because the decode
   // already happens during the setup cycle; it also keeps prdata,
   // pready and pslverr straight from flip-flops.

   // APB answer: decoded in the setup cycle, ready in the first access cycle
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & (kind == PPC_REG_NONE);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h00000000;
         case (kind)
            PPC_REG_PCR: begin
               prdata[15:0] <= pcr_low[pcr_index];
               prdata[`PPC_CFG_MSB:`PPC_CFG_LSB] <= irq_cfg[pcr_index];
               prdata[`PPC_FLAG_BIT] <= pin_event_flag[pcr_index];
            end
            PPC_REG_FLAGS:
               prdata[NUM_PINS-1:0] <= pin_event_flag;
            // Global registers are write-only
            PPC_REG_GPW_LOW,
            PPC_REG_GPW_HIGH:
               prdata <= 32'h00000000;
            default:
               prdata <= 32'h00000000;
         endcase
      end
   end


   // Per-pin logic.
   // Pad controls are registered one edge behind the control register and
   // the peripheral inputs. That adds one cycle of latency to every pad
   // change, traded for clean flip-flop outputs towards the pad ring.
   // The pad level is treated as already synchronous; a real pad needs a
   // synchroniser in front of pad_in before it reaches this block.
   // Edge detection compares the gated level with its registered copy, so
   // turning the mux off or disabling the port looks like a falling level;
   // software should disable events before parking a pin.
   // Level events are re-evaluated on every edge, which is what makes a
   // cleared flag come straight back while the level is still active.

   // Only the registers are reset; port_enable has no say, so settings survive it
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         logic       digital;
         logic       drive;
         logic       lvl;
         logic       pull_ok;
         logic [3:0] cfg_wr;

         assign digital = pcr_low[g][`PPC_MUX_MSB:`PPC_MUX_LSB] != `PPC_MUX_OFF;
         assign drive   = digital & periph_drive[g];
         // Input buffer follows the mux; the port must be running to see the pad
         assign lvl     = pad_in[g] & digital & port_enable;
         // Only special pins let a peripheral take the pull away
         assign pull_ok = ~(SPECIAL_PINS[g] & periph_pull_off[g]);
         assign cfg_wr  = IRQ_CAP[g] ? pwdata[`PPC_CFG_MSB:`PPC_CFG_LSB] : 4'h0;

         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n)
               pcr_low[g] <= `PPC_PCR_RESET;
            else if (wr_done && kind == PPC_REG_PCR && pcr_index == 5'(g))
               pcr_low[g] <= pwdata[15:0] & low_mask(g);
            else if (gpw_select[g])
               pcr_low[g] <= global_write_value & low_mask(g);
         end

         // Global writes do not reach this register at all
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n)
               irq_cfg[g] <= PPC_IRQ_OFF;
            else if (wr_done && kind == PPC_REG_PCR && pcr_index == 5'(g))
               irq_cfg[g] <= cfg_wr;
         end

         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n)
               level_q[g] <= 1'b0;
            else
               level_q[g] <= lvl;
         end

         always_comb begin
            case (irq_cfg[g])
               PPC_IRQ_RISE: event_hit[g] = lvl & ~level_q[g];
               PPC_IRQ_FALL: event_hit[g] = ~lvl & level_q[g];
               PPC_IRQ_BOTH: event_hit[g] = lvl ^ level_q[g];
               PPC_IRQ_LOW:  event_hit[g] = ~lvl & digital & port_enable;
               PPC_IRQ_HIGH: event_hit[g] = lvl;
               default:      event_hit[g] = 1'b0;
            endcase
         end

         assign irq_enabled[g] = irq_cfg[g] != PPC_IRQ_OFF;

         // A new event in the clearing cycle wins over the clear
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n)
               pin_event_flag[g] <= 1'b0;
            else if (IRQ_CAP[g])
               pin_event_flag[g] <= (pin_event_flag[g] & ~flag_clear[g])
                                    | event_hit[g];
         end

         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               pad_ctl[g]         <= '0;
               pad_ctl[g].out_en_n <= 1'b1;
               pad_out[g]         <= 1'b0;
               pin_input_level[g] <= 1'b0;
            end else begin
               pad_ctl[g].in_buf_en         <= digital;
               pad_ctl[g].out_en_n          <= ~drive;
               // Pull forced off while driving, stored bit left alone
               pad_ctl[g].pull_resistor_on  <= digital & ~drive & pull_ok
                                               & pcr_low[g][`PPC_PULL_ON_BIT];
               pad_ctl[g].pull_direction_up <= digital & pcr_low[g][`PPC_PULL_ON_BIT]
                                               & pcr_low[g][`PPC_PULL_DIR_BIT];
               pad_ctl[g].slow_slew_select  <= drive & pcr_low[g][`PPC_SLEW_BIT];
               pad_ctl[g].filter_en         <= digital & ~drive
                                               & pcr_low[g][`PPC_FILTER_BIT];
               pad_ctl[g].high_drive        <= drive & pcr_low[g][`PPC_DRIVE_BIT];
               pad_ctl[g].mux_sel           <= pcr_low[g][`PPC_MUX_MSB:`PPC_MUX_LSB];
               pad_out[g]                   <= drive & periph_out[g];
               pin_input_level[g]           <= lvl;
            end
         end
      end
   endgenerate


   // The port interrupt is a level: it stays high while any flag of a pin
   // with events configured is set, and falls one edge after the last of
   // them is cleared. A flag left behind after its pin was set to off does
   // not hold the interrupt up.

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         port_irq <= 1'b0;
      else
         port_irq <= |(pin_event_flag & irq_enabled);
   end

endmodule : ppc_port

`default_nettype wire

// ### rtl/ppc_map.svh
// Register offsets, field positions, reset values and timing of the port pin control block
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

`define PPC_ADDR_W        8
`define PPC_PCR_BASE      8'h00
`define PPC_PCR_LAST      8'h7C
`define PPC_GPW_LOW       8'h80
`define PPC_GPW_HIGH      8'h84
`define PPC_FLAGS         8'hA0

`define PPC_PULL_DIR_BIT  0
`define PPC_PULL_ON_BIT   1
`define PPC_SLEW_BIT      2
`define PPC_FILTER_BIT    4
`define PPC_DRIVE_BIT     6
`define PPC_MUX_LSB       8
`define PPC_MUX_MSB       10
`define PPC_CFG_LSB       16
`define PPC_CFG_MSB       19
`define PPC_FLAG_BIT      24
`define PPC_GPW_SEL_LSB   16

`define PPC_LOW_FIXED_MASK 16'h0750
`define PPC_PCR_RESET      16'h0000
`define PPC_MUX_OFF        3'h0
`define PPC_MUX_GPIO       3'h1

`define PPC_APB_WAIT       0

`endif

// ### rtl/ppc_pkg.sv
// Types shared by the port pin control block
package ppc_pkg;

   typedef enum logic [2:0] {
      PPC_REG_NONE,
      PPC_REG_PCR,
      PPC_REG_GPW_LOW,
      PPC_REG_GPW_HIGH,
      PPC_REG_FLAGS
   } ppc_reg_kind_t;

   typedef enum logic [3:0] {
      PPC_IRQ_OFF     = 4'h0,
      PPC_IRQ_RISE    = 4'h1,
      PPC_IRQ_FALL    = 4'h2,
      PPC_IRQ_BOTH    = 4'h3,
      PPC_IRQ_LOW     = 4'h4,
      PPC_IRQ_HIGH    = 4'h5
   } ppc_irq_cfg_t;

   typedef struct packed {
      logic       in_buf_en;
      logic       out_en_n;
      logic       pull_resistor_on;
      logic       pull_direction_up;
      logic       slow_slew_select;
      logic       filter_en;
      logic       high_drive;
      logic [2:0] mux_sel;
   } ppc_pad_ctl_t;

endpackage : ppc_pkg

// ### bench/ppc_port_assertions.sv
// Checker for bus timing and pad gating of the port pin control block
`timescale 1ns/1ns
`default_nettype none
`include "ppc_map.svh"
module ppc_port_assertions
   import ppc_pkg::*;
#(
   parameter int NUM_PINS = 32
) (
   // Clock, reset and bus
   input wire logic                        sys_clk,
   input wire logic                        arst_n,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [`PPC_ADDR_W-1:0]      paddr,
   input wire logic [31:0]                 prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   // Pads
   input wire logic                        port_enable,
   input wire ppc_pad_ctl_t [NUM_PINS-1:0] pad_ctl,
   input wire logic [NUM_PINS-1:0]         pin_input_level
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic setup;
   logic dark_bad;
   logic pull_bad;
   assign setup = psel && !penable;
   // Any pin breaking the gating raises the flag, so one property covers all pins
   always_comb begin
      dark_bad = 1'b0;
      pull_bad = 1'b0;
      for (int i = 0; i < NUM_PINS; i++) begin
         dark_bad |= (pad_ctl[i].mux_sel == `PPC_MUX_OFF) && (pad_ctl[i].in_buf_en ||
            pad_ctl[i].pull_resistor_on || !pad_ctl[i].out_en_n || pad_ctl[i].filter_en ||
            pin_input_level[i]);
         pull_bad |= !pad_ctl[i].out_en_n && pad_ctl[i].pull_resistor_on;
      end
   end
   property p_ready; setup |=> pready ##1 !pready; endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_misalign; setup && paddr[1:0] != 2'h0 |=> pslverr; endproperty
   property p_gpw_zero;
      setup && !pwrite && (paddr == `PPC_GPW_LOW || paddr == `PPC_GPW_HIGH)
         |=> prdata == 32'h0 && !pslverr;
   endproperty
   property p_hold; !(setup && !pwrite) |=> $stable(prdata); endproperty
   property p_dark; !dark_bad; endproperty
   property p_drive_pull; !pull_bad; endproperty
   property p_port_off; !port_enable |=> pin_input_level == '0; endproperty
   a_ready: assert property (p_ready) else $error("pready not a one cycle answer");
   a_err: assert property (p_err) else $error("pslverr without pready");
   a_misalign: assert property (p_misalign) else $error("misaligned access not refused");
   a_gpw_zero: assert property (p_gpw_zero) else $error("global write reg read nonzero");
   a_hold: assert property (p_hold) else $error("prdata changed outside read");
   a_dark: assert property (p_dark) else $error("digital function on muxed off pin");
   a_drive_pull: assert property (p_drive_pull) else $error("pull on while driving");
   a_port_off: assert property (p_port_off) else $error("input level seen with port off");
   c_write: cover property (setup && pwrite);
   c_err: cover property (pslverr);
   c_off: cover property (!port_enable);
endmodule : ppc_port_assertions
bind ppc_port ppc_port_assertions #(.NUM_PINS(NUM_PINS)) u_chk (.sys_clk, .arst_n, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .port_enable, .pad_ctl,
   .pin_input_level);
`default_nettype wire

// ### bench/tb.sv
// Self-checking testbench of the port pin control block
`timescale 1ns/1ns
`default_nettype none
`include "ppc_map.svh"
module tb;
   import ppc_pkg::*;
   logic               sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic               port_enable = 1, pready, pslverr, port_irq, err_q;
   logic [7:0]         paddr = 0;
   logic [31:0]        pwdata = 0, periph_drive = 0, periph_pull_off = 0, pad_in = 0;
   logic [31:0]        periph_out = 0;
   logic [31:0]        prdata, pad_out, pin_input_level, r;
   ppc_pad_ctl_t [31:0] pad_ctl;
   int                 n_errors = 0, num_checks = 0, cyc = 0;
   // Pin 1 lacks slew, pin 0 lacks pull direction, pin 31 lacks events
   ppc_port #(.SLEW_CAP(32'hFFFFFFFD), .PULL_DIR_CAP(32'hFFFFFFFE), .IRQ_CAP(32'h7FFFFFFF))
      dut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .port_enable, .periph_out, .periph_drive, .periph_pull_off, .pad_in,
      .pad_out, .pad_ctl, .pin_input_level, .port_irq);
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Entered just after an edge; leaves one idle cycle so no signal is assigned twice
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k == 16) n_errors++;
      r = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check($sformatf("reg %h", a), r, exp);
   endtask : rd
   task automatic t_reset();
      rd(8'h00, 32'h0);
      rd(`PPC_FLAGS, 32'h0);
      rd(`PPC_GPW_HIGH, 32'h0);
      rd(8'hC0, 32'h0);
      check("unmapped err", 32'(err_q), 32'h1);
      rd(8'h02, 32'h0);
      check("misaligned err", 32'(err_q), 32'h1);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_bits();
      wr(8'h0C, 32'h00000107);
      rd(8'h0C, 32'h00000107);
      check("in pull up", 32'({pad_ctl[3].in_buf_en, pad_ctl[3].pull_resistor_on,
         pad_ctl[3].pull_direction_up}), 32'h7);
      wr(8'h0C, 32'h00000106);
      @(posedge sys_clk);
      check("pull down", 32'({pad_ctl[3].pull_resistor_on, pad_ctl[3].pull_direction_up}),
         32'h2);
      periph_drive[3] <= 1'b1;
      periph_pull_off[3] <= 1'b1;
      periph_out[3] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      check("drive", 32'({pad_ctl[3].out_en_n, pad_ctl[3].pull_resistor_on}), 32'h0);
      check("slew out", 32'({pad_ctl[3].slow_slew_select, pad_out[3]}), 32'h3);
      rd(8'h0C, 32'h00000106);
      wr(8'h0C, 32'h00000006);
      @(posedge sys_clk);
      check("mux off", 32'(pad_ctl[3]), 32'h100);
      check("mux off out", 32'(pad_out[3]), 32'h0);
      periph_drive[3] <= 1'b0;
      wr(8'h0C, 32'h00000106);
      @(posedge sys_clk);
      check("pull kept", 32'(pad_ctl[3].pull_resistor_on), 32'h1);
      wr(8'h00, 32'h00000107);
      rd(8'h00, 32'h00000106);
      wr(8'h04, 32'h00000107);
      rd(8'h04, 32'h00000103);
      $display("t_bits done");
   endtask : t_bits
   task automatic t_global();
      wr(8'h14, 32'h00010000);
      wr(`PPC_GPW_LOW, 32'h00300102);
      rd(8'h10, 32'h00000102);
      rd(8'h14, 32'h00010102);
      rd(8'h18, 32'h0);
      wr(`PPC_GPW_HIGH, 32'h00010007);
      rd(8'h40, 32'h00000007);
      rd(8'h44, 32'h0);
      rd(`PPC_GPW_LOW, 32'h0);
      $display("t_global done");
   endtask : t_global
   task automatic t_events();
      pad_in[5] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check("irq set", 32'(port_irq), 32'h1);
      check("level", 32'(pin_input_level[5]), 32'h1);
      rd(`PPC_FLAGS, 32'h20);
      wr(`PPC_FLAGS, 32'h0);
      rd(`PPC_FLAGS, 32'h20);
      rd(8'h14, 32'h01010102);
      wr(8'h14, 32'h01010102);
      rd(`PPC_FLAGS, 32'h0);
      check("irq clear", 32'(port_irq), 32'h0);
      wr(8'h18, 32'h00050100);
      wr(8'h7C, 32'h00050100);
      pad_in[6] <= 1'b1;
      pad_in[31] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      wr(`PPC_FLAGS, 32'h40);
      rd(`PPC_FLAGS, 32'h40);
      rd(8'h7C, 32'h00000100);
      pad_in[6] <= 1'b0;
      repeat (3) @(posedge sys_clk);
      wr(`PPC_FLAGS, 32'h40);
      rd(`PPC_FLAGS, 32'h0);
      port_enable <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("port off level", pin_input_level, 32'h0);
      rd(8'h18, 32'h00050100);
      port_enable <= 1'b1;
      $display("t_events done");
   endtask : t_events
   initial begin
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_bits();
      t_global();
      t_events();
      final_report();
   end
endmodule : tb
`default_nettype wire
